// file: rtl/fgcs_host.sv
/*
 Host page-program sequencer driving a page flash over a memory bus:
 address bits choose data, command or address port.
 Assumes the user supplies page data bytes on a valid/ready handshake.
*/
// Functional notes
// - Address bit 5 address select, bit 4 command
// - Offsets 0x, 1x, 2x; never both bits
// - Command byte written to command port
// - Address bytes written in order to address port
// - Host software owns error-correction codes
// - Setup, five addresses, data, then confirm
// - Poll status bit 6 until ready
// - Partial program count limited per page
// - Correct one bit per 512 bytes
`timescale 1ns/1ps
module fgcs_host
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // User orders
   input wire logic start,
   input wire logic slc_part,
   input wire logic [fgcs_pkg::ADDR_CYCLES*8-1:0] page_addr,
   input wire logic [11:0] byte_count,
   input wire logic [3:0] prior_programs,
   input wire logic [7:0] wdata,
   input wire logic wdata_valid,
   output logic wdata_ready,
   output logic busy,
   output logic done,
   output logic refused,
   output logic timeout,
   // Flash bus
   output logic [fgcs_pkg::ADDR_W-1:0] mem_addr,
   output logic [7:0] mem_dq_out,
   output logic mem_dq_oe,
   input wire logic [7:0] mem_dq_in,
   output logic mem_we_n,
   output logic mem_re_n
);
   import fgcs_pkg::*;
   // ==========================================================
   // Reset and input synchronisers
   logic [1:0] rst_sync_r;
   logic rst_s_n;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         rst_sync_r <= 2'b00;
      else
         rst_sync_r <= {rst_sync_r[0], 1'b1};
   end
   assign rst_s_n = rst_sync_r[1];
   logic [7:0] dq_m_r, dq_s_r;
   always_ff @(posedge mclk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         dq_m_r <= 8'h00;
         dq_s_r <= 8'h00;
      end
      else
      begin
         dq_m_r <= mem_dq_in;
         dq_s_r <= dq_m_r;
      end
   end
   // ==========================================================
   // Strobe timer
   logic stb_go, stb_busy;
   fgcs_strobe u_stb
   (
      .mclk(mclk),
      .rst_n(rst_s_n),
      .start(stb_go),
      .busy(stb_busy)
   );
   // ==========================================================
   // Sequencer
   fgcs_state_t st_r, st_nxt;
   logic [2:0] acnt_r, acnt_nxt;
   logic [11:0] bcnt_r, bcnt_nxt;
   logic [15:0] tmo_r, tmo_nxt;
   logic [ADDR_CYCLES*8-1:0] pa_r, pa_nxt;
   logic [7:0] a_r, a_nxt, d_r, d_nxt;
   logic oe_r, oe_nxt, we_r, we_nxt, re_r, re_nxt, rdy_r, rdy_nxt;
   logic busy_r, busy_nxt, done_r, done_nxt, ref_r, ref_nxt, tmo_f_r, tmo_f_nxt;
   logic stb_go_r, stb_go_nxt, issued;
   logic [3:0] limit;
   // Host software runs ECC; this block moves raw bytes
   assign limit = slc_part ? 4'(SLC_PROG_LIMIT) : 4'(MLC_PROG_LIMIT);
   assign stb_go = stb_go_r;
   assign issued = !stb_busy && !stb_go_r;
   always_comb
   begin
      st_nxt = st_r;
      acnt_nxt = acnt_r;
      bcnt_nxt = bcnt_r;
      tmo_nxt = tmo_r;
      pa_nxt = pa_r;
      a_nxt = a_r;
      d_nxt = d_r;
      oe_nxt = oe_r;
      we_nxt = 1'b1;
      re_nxt = 1'b1;
      rdy_nxt = 1'b0;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      ref_nxt = 1'b0;
      tmo_f_nxt = 1'b0;
      stb_go_nxt = 1'b0;
      if (!issued)
      begin
         // Hold low while strobe runs; release edge latches byte
         we_nxt = we_r;
         re_nxt = re_r;
      end
      else if (!we_r)
      begin
         // One high cycle between writes, else the flash sees no edge
         we_nxt = 1'b1;
      end
      else
      begin
         case (st_r)
            ST_IDLE:
            begin
               oe_nxt = 1'b0;
               if (start)
               begin
                  if (prior_programs >= limit || byte_count > 12'(PAGE_BYTES))
                     ref_nxt = 1'b1;
                  else
                  begin
                     busy_nxt = 1'b1;
                     pa_nxt = page_addr;
                     bcnt_nxt = byte_count;
                     st_nxt = ST_CMD;
                  end
               end
            end
            ST_CMD:
            begin
               a_nxt = CMD_PORT_OFS;
               d_nxt = CMD_PROG_SETUP;
               oe_nxt = 1'b1;
               we_nxt = 1'b0;
               stb_go_nxt = 1'b1;
               acnt_nxt = 3'h0;
               st_nxt = ST_ADDR;
            end
            ST_ADDR:
            begin
               a_nxt = ADDR_PORT_OFS;
               d_nxt = pa_r[7:0];
               pa_nxt = pa_r >> 8;
               we_nxt = 1'b0;
               stb_go_nxt = 1'b1;
               acnt_nxt = acnt_r + 3'h1;
               if (acnt_r == 3'(ADDR_CYCLES - 1))
                  st_nxt = (bcnt_r == 12'h0) ? ST_CONF : ST_DATA;
            end
            ST_DATA:
            begin
               a_nxt = DATA_PORT_OFS;
               rdy_nxt = !wdata_ready;
               // Ready pulses one cycle so each byte is taken once
               if (wdata_valid && wdata_ready)
               begin
                  rdy_nxt = 1'b0;
                  d_nxt = wdata;
                  we_nxt = 1'b0;
                  stb_go_nxt = 1'b1;
                  bcnt_nxt = bcnt_r - 12'h1;
                  if (bcnt_r == 12'h1)
                     st_nxt = ST_CONF;
               end
            end
            ST_CONF:
            begin
               a_nxt = CMD_PORT_OFS;
               d_nxt = CMD_PROG_CONFIRM;
               we_nxt = 1'b0;
               stb_go_nxt = 1'b1;
               st_nxt = ST_STCMD;
            end
            ST_STCMD:
            begin
               a_nxt = CMD_PORT_OFS;
               d_nxt = CMD_READ_STATUS;
               we_nxt = 1'b0;
               stb_go_nxt = 1'b1;
               tmo_nxt = 16'h0;
               st_nxt = ST_POLL;
            end
            ST_POLL:
            begin
               a_nxt = DATA_PORT_OFS;
               oe_nxt = 1'b0;
               if (re_r == 1'b0)
               begin
                  // Status taken through the two-flop synchroniser, before the read strobe is released
                  // One read is set, strobe, check and release cycles
                  tmo_nxt = tmo_r + 16'(STROBE_CYCLES + 3);
                  if (dq_s_r[STATUS_READY_BIT])
                     st_nxt = ST_DONE;
                  else if (tmo_r >= 16'(PROG_TIMEOUT_CYC))
                  begin
                     tmo_f_nxt = 1'b1;
                     st_nxt = ST_DONE;
                  end
               end
               else
               begin
                  re_nxt = 1'b0;
                  stb_go_nxt = 1'b1;
               end
            end
            default:
            begin
               busy_nxt = 1'b0;
               done_nxt = 1'b1;
               st_nxt = ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge mclk or negedge rst_s_n)
   begin
      if (!rst_s_n)
      begin
         st_r <= ST_IDLE;
         acnt_r <= 3'h0;
         bcnt_r <= 12'h000;
         tmo_r <= 16'h0000;
         pa_r <= '0;
         a_r <= 8'h00;
         d_r <= 8'h00;
         oe_r <= 1'b0;
         we_r <= 1'b1;
         re_r <= 1'b1;
         rdy_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         ref_r <= 1'b0;
         tmo_f_r <= 1'b0;
         stb_go_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         acnt_r <= acnt_nxt;
         bcnt_r <= bcnt_nxt;
         tmo_r <= tmo_nxt;
         pa_r <= pa_nxt;
         a_r <= a_nxt;
         d_r <= d_nxt;
         oe_r <= oe_nxt;
         we_r <= we_nxt;
         re_r <= re_nxt;
         rdy_r <= rdy_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         ref_r <= ref_nxt;
         tmo_f_r <= tmo_f_nxt;
         stb_go_r <= stb_go_nxt;
      end
   end
   // Page load time is only used by read flows, not here
   assign mem_addr = a_r;
   assign mem_dq_out = d_r;
   assign mem_dq_oe = oe_r;
   assign mem_we_n = we_r;
   assign mem_re_n = re_r;
   assign wdata_ready = rdy_r;
   assign busy = busy_r;
   assign done = done_r;
   assign refused = ref_r;
   assign timeout = tmo_f_r;
endmodule // fgcs_host

// file: rtl/fgcs_pkg.sv
/*
 Package for the glueless page-flash host sequencer: port offsets,
 command codes, status bit, timing and count limits.
 Assumes a 40 MHz mclk and an 8-bit flash reached over a memory bus.
*/
package fgcs_pkg;
   // ==========================================================
   // Bus offsets and select bits
   localparam int ADDR_W = 8;
   localparam logic [7:0] DATA_PORT_OFS = 8'h00;
   localparam logic [7:0] CMD_PORT_OFS = 8'h10;
   localparam logic [7:0] ADDR_PORT_OFS = 8'h20;
   localparam int ALE_BIT = 5;
   localparam int CLE_BIT = 4;
   // ==========================================================
   // Commands and status
   localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
   localparam logic [7:0] CMD_PROG_CONFIRM = 8'h10;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   localparam int STATUS_READY_BIT = 6;
   localparam int ADDR_CYCLES = 5;
   // ==========================================================
   // Limits and timing
   localparam int PAGE_BYTES = 2112;
   localparam int ECC_SECTOR_BYTES = 512;
   localparam int ECC_MIN_BITS = 1;
   localparam int MLC_PROG_LIMIT = 1;
   localparam int SLC_PROG_LIMIT = 8;
   localparam int CLK_MHZ = 40;
   localparam int STROBE_CYCLES = 2;
   localparam int PROG_TIME_MLC_US = 1200;
   localparam int PROG_TIME_SLC_US = 700;
   localparam int LOAD_TIME_MLC_US = 50;
   localparam int LOAD_TIME_SLC_US = 25;
   localparam int PROG_TIMEOUT_CYC = PROG_TIME_MLC_US * CLK_MHZ;
   localparam int LOAD_CYC_MLC = LOAD_TIME_MLC_US * CLK_MHZ;
   localparam int LOAD_CYC_SLC = LOAD_TIME_SLC_US * CLK_MHZ;
   typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DATA, ST_CONF, ST_STCMD, ST_POLL,
      ST_DONE} fgcs_state_t;
endpackage

// file: rtl/fgcs_strobe.sv
/*
 One bus write or read strobe of fixed width.
 Assumes the flash samples on the rising edge of its write strobe.
*/
`timescale 1ns/1ps
module fgcs_strobe
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   output logic busy
);
   import fgcs_pkg::*;
   logic [3:0] cnt_r, cnt_nxt;
   always_comb
   begin
      cnt_nxt = cnt_r;
      if (start)
         cnt_nxt = 4'(STROBE_CYCLES);
      else if (cnt_r != 4'h0)
         cnt_nxt = cnt_r - 4'h1;
   end
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         cnt_r <= 4'h0;
      else
         cnt_r <= cnt_nxt;
   end
   assign busy = (cnt_r != 4'h0);
endmodule // fgcs_strobe

// file: testbench/fgcs_flash_model.sv
/* Behavioural page flash on a multiplexed bus.
   Assumes writes land as the write strobe rises. */
`timescale 1ns/1ps
module fgcs_flash_model
#(
   parameter int PROG_MLC = 300,
   parameter int PROG_SLC = 120
)
(
   // Clock, reset, part
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic slc_part,
   // Flash bus
   input wire logic [fgcs_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_dq_out,
   input wire logic mem_dq_oe,
   input wire logic mem_we_n,
   input wire logic mem_re_n,
   output logic [7:0] mem_dq_in,
   // Observation
   output logic [15:0] progs,
   output logic [15:0] n_addr,
   output logic [15:0] n_data,
   output logic [15:0] sum,
   output logic [39:0] alog,
   output logic abusy
);
   import fgcs_pkg::*;
   logic we_q, re_q, wr;
   logic [7:0] st_q;
   int cnt;
   assign abusy = cnt != 0;
   assign wr = mem_we_n && !we_q;
   // Released bus shows inverted status, never a stale copy
   assign mem_dq_in = mem_dq_oe ? mem_dq_out : (mem_re_n ? ~st_q : st_q);
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {we_q, re_q, st_q, cnt} <= {2'b11, 8'h00, 32'h0};
         {progs, n_addr, n_data, sum, alog} <= '0;
      end
      else
      begin
         we_q <= mem_we_n;
         re_q <= mem_re_n;
         if (cnt > 0)
            cnt <= cnt - 1;
         if (!mem_re_n && re_q)
            st_q <= {1'b1, cnt == 0, 6'h00};
         if (wr && mem_addr[CLE_BIT] && !mem_addr[ALE_BIT])
         begin
            if (mem_dq_out == CMD_PROG_SETUP)
               {n_addr, n_data, sum} <= '0;
            if (mem_dq_out == CMD_PROG_CONFIRM)
               progs <= progs + 16'h1;
            if (mem_dq_out == CMD_PROG_CONFIRM)
               cnt <= slc_part ? PROG_SLC : PROG_MLC;
         end
         if (wr && mem_addr[ALE_BIT] && !mem_addr[CLE_BIT])
         begin
            alog <= {mem_dq_out, alog[39:8]};
            n_addr <= n_addr + 16'h1;
         end
         if (wr && !mem_addr[ALE_BIT] && !mem_addr[CLE_BIT])
         begin
            n_data <= n_data + 16'h1;
            sum <= sum + 16'(mem_dq_out);
         end
      end
   end
endmodule // fgcs_flash_model

// file: testbench/fgcs_host_properties.sv
/* Port checker for fgcs_host.
   Assumes it is bound to every fgcs_host. */
`timescale 1ns/1ps
module fgcs_host_chk
(
   // Watched ports
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic wdata_ready,
   input wire logic busy,
   input wire logic refused,
   input wire logic [fgcs_pkg::ADDR_W-1:0] mem_addr,
   input wire logic [7:0] mem_dq_out,
   input wire logic mem_dq_oe,
   input wire logic mem_we_n,
   input wire logic mem_re_n
);
   import fgcs_pkg::*;
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Strobes
   a_strobe_excl: assert property (mem_we_n || mem_re_n)
      else $error("both strobes low");
   a_no_both_sel: assert property (!(mem_we_n && mem_re_n) |-> !(mem_addr[5] && mem_addr[4]))
      else $error("both selects set");
   a_we_width: assert property ($fell(mem_we_n) |-> !mem_we_n[*4] ##1 mem_we_n)
      else $error("write strobe width");
   a_bus_hold: assert property (!mem_we_n && !$fell(mem_we_n) |->
      $stable(mem_addr) && $stable(mem_dq_out))
      else $error("bus moved in strobe");
   a_write_drives: assert property (!mem_we_n |-> mem_dq_oe && busy)
      else $error("write not driven");
   a_read_data: assert property (!mem_re_n |-> mem_addr == DATA_PORT_OFS && !mem_dq_oe)
      else $error("read off data port");
   // ==========================================
   // Sequence
   a_setup_first: assert property ($rose(busy) && !refused |-> ##1 ($fell(mem_we_n)
      && mem_addr == CMD_PORT_OFS && mem_dq_out == CMD_PROG_SETUP))
      else $error("setup not first");
   a_ready_pulse: assert property (wdata_ready |=> !wdata_ready)
      else $error("ready too long");
endmodule // fgcs_host_chk

bind fgcs_host fgcs_host_chk u_chk (.mclk(mclk), .rst_n(rst_n), .wdata_ready(wdata_ready),
   .busy(busy), .refused(refused), .mem_addr(mem_addr), .mem_dq_out(mem_dq_out),
   .mem_dq_oe(mem_dq_oe), .mem_we_n(mem_we_n), .mem_re_n(mem_re_n));

// file: testbench/fgcs_host_tb_top.sv
/* Self-checking bench for fgcs_host against a flash model.
   Assumes the model and checker files are compiled first. */
`timescale 1ns/1ps
module fgcs_host_tb_top;
   import fgcs_pkg::*;
   logic mclk, rst_n, start, slc_part, wdata_valid, wdata_ready, busy, done, refused, abusy;
   logic timeout;
   logic [39:0] page_addr, alog;
   logic [11:0] byte_count;
   logic [3:0] prior_programs;
   logic [7:0] wdata, mem_addr, mem_dq_out, mem_dq_in;
   logic mem_dq_oe, mem_we_n, mem_re_n;
   logic [15:0] progs, n_addr, n_data, sum;
   int err_count, n_tests;
   fgcs_host dut (.mclk(mclk), .rst_n(rst_n), .start(start), .slc_part(slc_part),
      .page_addr(page_addr), .byte_count(byte_count), .prior_programs(prior_programs),
      .wdata(wdata), .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .busy(busy),
      .done(done), .refused(refused), .timeout(timeout), .mem_addr(mem_addr),
      .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe), .mem_dq_in(mem_dq_in),
      .mem_we_n(mem_we_n), .mem_re_n(mem_re_n));
   fgcs_flash_model u_flash (.mclk(mclk), .rst_n(rst_n), .slc_part(slc_part),
      .mem_addr(mem_addr), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe),
      .mem_we_n(mem_we_n), .mem_re_n(mem_re_n), .mem_dq_in(mem_dq_in), .progs(progs),
      .n_addr(n_addr), .n_data(n_data), .sum(sum), .alog(alog), .abusy(abusy));
   // ==========================================
   // Checking
   task chk(input logic [39:0] g, input logic [39:0] e);
      n_tests++;
      if (g !== e)
      begin
         err_count++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task summarize;
      $display("checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   function automatic logic exp_ref(logic s, logic [3:0] p, logic [11:0] c);
      return p >= (s ? SLC_PROG_LIMIT : MLC_PROG_LIMIT) || c > PAGE_BYTES;
   endfunction
   // ==========================================
   // One program order; dbl repeats start while busy
   task automatic run(input logic s, input logic [3:0] p, input logic [11:0] c, input logic dbl);
      logic [15:0] p0, es;
      logic gd, gr, gt, pend;
      {p0, es, gd, gr, gt, pend} = {progs, 16'h0, 4'h0};
      {slc_part, prior_programs, byte_count} = {s, p, c};
      page_addr = {8'($urandom), $urandom};
      wdata = 8'($urandom);
      start = 1'b1;
      for (int k = 0; k < 20000 && !gd && !gr; k++)
      begin
         @(posedge mclk);
         #2;
         start = dbl && k == 40;
         if (pend)
            es = es + 16'(wdata);
         if (pend)
            wdata = 8'($urandom);
         // Offer held until taken; gaps may come before any byte but the first, which is offered from the start
         if (pend || !wdata_valid)
            wdata_valid = ($urandom_range(3) != 0);
         {pend, gd, gr} = {wdata_ready && wdata_valid, done, refused};
         gt = gt | timeout;
      end
      if (!gd && !gr)
      begin
         err_count++;
         summarize;
      end
      else
      begin
         chk(gr, exp_ref(s, p, c));
         chk(progs, p0 + (exp_ref(s, p, c) ? 16'h0 : 16'h1));
         chk(gt, 1'b0);
         if (gd)
         begin
            chk(alog, page_addr);
            chk(n_addr, ADDR_CYCLES);
            chk(n_data, c);
            chk(sum, es);
            chk(abusy, 1'b0);
         end
         $display("test end slc %0d prior %0d count %0d", s, p, c);
      end
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      {rst_n, start, slc_part, page_addr, byte_count, prior_programs, wdata} = '0;
      {wdata_valid, err_count, n_tests} = {1'b1, 64'h0};
      void'($urandom(94694));
      repeat (12) @(posedge mclk);
      #2 rst_n = 1'b1;
      repeat (3) @(posedge mclk);
      #2;
      run(1'b0, 4'h0, 12'h004, 1'b0);
      run(1'b1, 4'h7, 12'h840, 1'b0);
      run(1'b1, 4'h8, 12'h003, 1'b0);
      run(1'b0, 4'h1, 12'h003, 1'b0);
      run(1'b1, 4'h0, 12'h841, 1'b0);
      run(1'b0, 4'h0, 12'h001, 1'b1);
      repeat (6) run(1'($urandom), 4'($urandom_range(9)), 12'($urandom_range(1, 24)), 1'b0);
      summarize;
   end
endmodule // fgcs_host_tb_top
